// *** inc/spcs_pkg.sv ***
// Package for the receive channel-status register bank.
// Assumes register indices are byte addresses on the serial control port.
`default_nettype none
package spcs_pkg;
   // Register indices
   localparam logic [6:0] SPCS_ADDR_SPDSTAT = 7'h0c;
   localparam logic [6:0] SPCS_ADDR_CHAN1   = 7'h0d;
   localparam logic [6:0] SPCS_ADDR_CHAN2   = 7'h0e;
   localparam logic [6:0] SPCS_ADDR_CHAN3   = 7'h0f;
   localparam logic [6:0] SPCS_ADDR_CHAN4   = 7'h10;
   // Field positions
   localparam int SPCS_RATE_LSB   = 4;
   localparam int SPCS_UNLOCK_BIT = 6;
   localparam int SPCS_USE_BIT    = 0;
   localparam int SPCS_PCM_BIT    = 1;
   localparam int SPCS_CPY_BIT    = 2;
   localparam int SPCS_EMPH_BIT   = 3;
   localparam int SPCS_MODE_LSB   = 6;
   localparam int SPCS_SRC_LSB    = 0;
   localparam int SPCS_CH1_LSB    = 4;
   localparam int SPCS_CH2_LSB    = 6;
   localparam int SPCS_INDICATED_RATE_CODE_LSB   = 0;
   // Channel-status bit positions inside a 192-bit block
   localparam int SPCS_BLOCK_BITS = 192;
   localparam int SPCS_CS_INDICATED_RATE_CODE    = 24;
   // Reset values
   localparam logic [7:0] SPCS_RST_CHAN1 = 8'h00;
   localparam logic [7:0] SPCS_RST_CHAN2 = 8'h00;
   localparam logic [7:0] SPCS_RST_CHAN3 = 8'h00;
   localparam logic [7:0] SPCS_RST_CHAN4 = 8'h01;
   localparam logic [1:0] SPCS_RST_RATE  = 2'h2;
   // Rate classes
   localparam logic [1:0] SPCS_RATE_192 = 2'h0;
   localparam logic [1:0] SPCS_RATE_96  = 2'h1;
   localparam logic [1:0] SPCS_RATE_48  = 2'h2;
   localparam logic [1:0] SPCS_RATE_32  = 2'h3;
   typedef enum logic [1:0] {
      SPCS_IDLE = 2'b00,
      SPCS_FILL = 2'b01,
      SPCS_CHK  = 2'b11
   } spcs_state_e;
endpackage
`default_nettype wire

// *** core/spcs_capture.sv ***
// Channel-status block collector: shifts the first CAP_BITS status bits of each block, one per frame, and checks consistency.
// Assumes a block-start strobe on the first bit of each 192-bit block.
`default_nettype none
module spcs_capture
   import spcs_pkg::*;
#(
   parameter int CAP_BITS = 32
) (
   input  wire logic                core_clk_in,  // Core clock
   input  wire logic                nrst_in,      // Async reset, active low
   input  wire logic                cs_bit_in,    // Channel-status bit
   input  wire logic                cs_valid_in,  // Bit strobe
   input  wire logic                cs_start_in,  // First bit of block
   output logic      [CAP_BITS-1:0] block_out,    // Consistent captured block
   output logic                     update_out    // Pulse on new block
);
   spcs_state_e           state, next_state;
   logic [CAP_BITS-1:0]   shreg, next_shreg, prev, next_prev, next_block;
   logic [7:0]            cnt, next_cnt;
   logic                  next_update;

   always_comb begin
      next_state  = state;
      next_shreg  = shreg;
      next_prev   = prev;
      next_block  = block_out;
      next_cnt    = cnt;
      next_update = 1'b0;
      case (state)
         SPCS_IDLE: begin
            if (cs_valid_in && cs_start_in) begin
               next_shreg = {cs_bit_in, shreg[CAP_BITS-1:1]};
               next_cnt   = 8'h01;
               next_state = SPCS_FILL;
            end
         end
         SPCS_FILL: begin
            if (cs_valid_in && cs_start_in) begin
               next_shreg = {cs_bit_in, shreg[CAP_BITS-1:1]};
               next_cnt   = 8'h01;
            end else if (cs_valid_in) begin
               if (cnt < 8'(CAP_BITS))
                  next_shreg = {cs_bit_in, shreg[CAP_BITS-1:1]};
               next_cnt = cnt + 8'h01;
               if (next_cnt == 8'(SPCS_BLOCK_BITS))
                  next_state = SPCS_CHK;
            end
         end
         SPCS_CHK: begin
            // Publish only when two successive blocks agree
            if (shreg == prev && shreg != block_out) begin
               next_block  = shreg;
               next_update = 1'b1;
            end
            next_prev  = shreg;
            next_state = SPCS_IDLE;
         end
         default: next_state = SPCS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state      <= SPCS_IDLE;
         shreg      <= '0;
         prev       <= '0;
         block_out  <= '0;
         cnt        <= 8'h00;
         update_out <= 1'b0;
      end else begin
         state      <= next_state;
         shreg      <= next_shreg;
         prev       <= next_prev;
         block_out  <= next_block;
         cnt        <= next_cnt;
         update_out <= next_update;
      end
   end
endmodule
`default_nettype wire

// *** core/spcs_regs.sv ***
// Receive channel-status register bank with lock and rate status.
// Assumes a simple synchronous read/write port from the serial control decoder.
`default_nettype none
module spcs_regs
   import spcs_pkg::*;
(
   input  wire logic       core_clk_in,     // Core clock, 200 MHz
   input  wire logic       nrst_in,         // Async reset, active low
   input  wire logic       cs_bit_in,       // Recovered channel-status bit
   input  wire logic       cs_valid_in,     // One pulse per frame with a status bit
   input  wire logic       cs_start_in,     // Marks the first bit of a block
   input  wire logic       unlock_in,       // Clock recovery unlocked
   input  wire logic [1:0] rate_class_in,   // Measured rate class
   input  wire logic       pcm_sync_in,     // Non-PCM sync code detected
   input  wire logic [6:0] reg_addr_in,     // Register address
   input  wire logic       reg_rd_in,       // Read strobe
   input  wire logic       reg_wr_in,       // Write strobe (ignored)
   input  wire logic [7:0] reg_wdata_in,    // Write data (ignored)
   output logic      [7:0] reg_rdata_out,   // Read data
   output logic            reg_rvalid_out,  // Read data valid pulse
   output logic            lock_change_cause_out // Pulse on unlock toggle
);
   // -----------------------------------------------------------------
   // Block capture
   // -----------------------------------------------------------------
   logic [31:0] blk;
   logic        blk_upd;

   spcs_capture #(
      .CAP_BITS (32)
   ) u_cap (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .cs_bit_in   (cs_bit_in),
      .cs_valid_in (cs_valid_in),
      .cs_start_in (cs_start_in),
      .block_out   (blk),
      .update_out  (blk_upd)
   );

   // -----------------------------------------------------------------
   // Channel-status words
   // -----------------------------------------------------------------
   logic [7:0] chan1, chan2, chan3, chan4;
   logic [7:0] next_chan1, next_chan2, next_chan3, next_chan4;

   always_comb begin
      next_chan1 = chan1;
      next_chan2 = chan2;
      next_chan3 = chan3;
      next_chan4 = chan4;
      if (blk_upd) begin
         next_chan1[SPCS_USE_BIT]  = blk[0];
         next_chan1[SPCS_PCM_BIT]  = blk[1];
         next_chan1[SPCS_CPY_BIT]  = blk[2];
         next_chan1[SPCS_EMPH_BIT] = blk[3];
         next_chan1[5:4]           = 2'h0;
         next_chan1[SPCS_MODE_LSB +: 2] = blk[7:6];
         next_chan2 = blk[15:8];
         next_chan3[SPCS_SRC_LSB +: 4] = blk[19:16];
         next_chan3[SPCS_CH1_LSB +: 2] = blk[21:20];
         next_chan3[SPCS_CH2_LSB +: 2] = blk[23:22];
         next_chan4 = {4'h0, blk[SPCS_CS_INDICATED_RATE_CODE +: 4]};
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         chan1 <= SPCS_RST_CHAN1;
         chan2 <= SPCS_RST_CHAN2;
         chan3 <= SPCS_RST_CHAN3;
         chan4 <= SPCS_RST_CHAN4;
      end else begin
         chan1 <= next_chan1;
         chan2 <= next_chan2;
         chan3 <= next_chan3;
         chan4 <= next_chan4;
      end
   end

   // -----------------------------------------------------------------
   // Live receiver status word
   // -----------------------------------------------------------------
   logic [7:0] spdstat, next_spdstat;

   always_comb begin
      next_spdstat                     = 8'h00;
      next_spdstat[0]                  = chan1[SPCS_PCM_BIT];
      next_spdstat[SPCS_PCM_BIT]       = pcm_sync_in;
      next_spdstat[SPCS_CPY_BIT]       = chan1[SPCS_CPY_BIT];
      next_spdstat[SPCS_EMPH_BIT]      = chan1[SPCS_EMPH_BIT];
      next_spdstat[SPCS_RATE_LSB +: 2] = rate_class_in;
      next_spdstat[SPCS_UNLOCK_BIT]    = unlock_in;
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in)
         spdstat <= {2'b01, SPCS_RST_RATE, 4'h0};                 // Unlocked until the first edge
      else
         spdstat <= next_spdstat;
   end

   // -----------------------------------------------------------------
   // Lock-change cause
   // -----------------------------------------------------------------
   logic unlock_q, next_unlock_q, next_cause;

   always_comb begin
      next_unlock_q = unlock_in;
      next_cause    = unlock_in ^ unlock_q;
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         unlock_q              <= 1'b1;                           // Same start as the status word
         lock_change_cause_out <= 1'b0;
      end else begin
         unlock_q              <= next_unlock_q;
         lock_change_cause_out <= next_cause;
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   logic [7:0] next_rdata;
   logic       next_rvalid;

   always_comb begin
      next_rdata  = reg_rdata_out;
      next_rvalid = reg_rd_in;
      if (reg_rd_in) begin
         case (reg_addr_in)
            SPCS_ADDR_SPDSTAT: next_rdata = spdstat;
            SPCS_ADDR_CHAN1:   next_rdata = chan1;
            SPCS_ADDR_CHAN2:   next_rdata = chan2;
            SPCS_ADDR_CHAN3:   next_rdata = chan3;
            SPCS_ADDR_CHAN4:   next_rdata = chan4;
            default:           next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_rdata_out  <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rdata_out  <= next_rdata;
         reg_rvalid_out <= next_rvalid;
      end
   end
   // Writes have no effect on these read-only words
endmodule
`default_nettype wire

// *** tb/spcs_regs_properties.sv ***
// Checker for the channel-status register bank, bound onto spcs_regs.
// Assumes the bench keeps unlock_in steady through reset.
`default_nettype none
module spcs_regs_chk
   import spcs_pkg::*;
(
   input wire logic       core_clk_in,          // Clock
   input wire logic       nrst_in,              // Reset, active low
   input wire logic       cs_bit_in,            // Status bit
   input wire logic       cs_valid_in,          // Bit strobe
   input wire logic       cs_start_in,          // Block start
   input wire logic       unlock_in,            // Unlocked
   input wire logic [1:0] rate_class_in,        // Rate class
   input wire logic       pcm_sync_in,          // Non-PCM sync
   input wire logic [6:0] reg_addr_in,          // Address
   input wire logic       reg_rd_in,            // Read
   input wire logic       reg_wr_in,            // Write
   input wire logic [7:0] reg_wdata_in,         // Write data
   input wire logic [7:0] reg_rdata_out,        // Read data
   input wire logic       reg_rvalid_out,       // Read valid
   input wire logic       lock_change_cause_out // Cause pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_steady;
      ($stable(unlock_in) && $stable(rate_class_in))[*3];
   endsequence
   sequence s_stat_rd;
      s_steady ##0 (reg_rd_in && reg_addr_in == SPCS_ADDR_SPDSTAT);
   endsequence
   AST_RD_ANSWER: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read not answered");
   AST_UNLOCK_BIT: assert property (s_stat_rd |=> reg_rdata_out[6] == $past(unlock_in, 2))
      else $error("unlock bit wrong");
   AST_RATE_FIELD: assert property (s_stat_rd |=> reg_rdata_out[5:4] == $past(rate_class_in, 2))
      else $error("rate class wrong");
   AST_RSVD_ZERO: assert property (reg_rd_in && reg_addr_in == SPCS_ADDR_CHAN1 |=> reg_rdata_out[5:4] == 2'h0)
      else $error("reserved bits set");
   AST_INDICATED_RATE_CODE_HIGH: assert property (reg_rd_in && reg_addr_in == SPCS_ADDR_CHAN4 |=> reg_rdata_out[7:4] == 4'h0)
      else $error("rate word high bits set");
   AST_CAUSE: assert property ($changed(unlock_in) |-> ##1 lock_change_cause_out)
      else $error("no cause pulse");
   AST_CAUSE_ONLY: assert property (lock_change_cause_out |-> $past(unlock_in) != $past(unlock_in, 2))
      else $error("spurious cause pulse");
   AST_WR_IGNORED: assert property (reg_wr_in && !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("write changed read data");
   AST_UNMAPPED: assert property (reg_rd_in && reg_addr_in > SPCS_ADDR_CHAN4 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind spcs_regs spcs_regs_chk i_chk (
   .core_clk_in           (core_clk_in),
   .nrst_in               (nrst_in),
   .cs_bit_in             (cs_bit_in),
   .cs_valid_in           (cs_valid_in),
   .cs_start_in           (cs_start_in),
   .unlock_in             (unlock_in),
   .rate_class_in         (rate_class_in),
   .pcm_sync_in           (pcm_sync_in),
   .reg_addr_in           (reg_addr_in),
   .reg_rd_in             (reg_rd_in),
   .reg_wr_in             (reg_wr_in),
   .reg_wdata_in          (reg_wdata_in),
   .reg_rdata_out         (reg_rdata_out),
   .reg_rvalid_out        (reg_rvalid_out),
   .lock_change_cause_out (lock_change_cause_out)
);
`default_nettype wire

// *** tb/spcs_src.sv ***
// Upstream source model: sends 192-bit channel-status blocks.
// Assumes the caller drives it from the bench clock.
`default_nettype none
module spcs_src
   import spcs_pkg::*;
(
   input  wire logic clk_in,       // Core clock
   output logic      cs_bit_out,   // Status bit
   output logic      cs_valid_out, // Bit strobe
   output logic      cs_start_out  // Block start
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cs_bit_out = 1'b0;
      cs_valid_out = 1'b0;
      cs_start_out = 1'b0;
   end
   // LSB first, one bit every second cycle; line inverted between strobes
   task automatic send_block(input logic [31:0] word);
      logic b;
      for (int n = 0; n < SPCS_BLOCK_BITS; n++) begin
         b = (n < 32) ? word[n] : 1'b0;
         @(negedge clk_in);
         cs_bit_out = b;
         cs_valid_out = 1'b1;
         cs_start_out = (n == 0);
         @(negedge clk_in);
         cs_bit_out = ~b;
         cs_valid_out = 1'b0;
         cs_start_out = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** tb/spcs_regs_tb.sv ***
// Testbench for the channel-status register bank.
// Assumes a 200 MHz clock and the source model in spcs_src.
`default_nettype none
module spcs_regs_tb
   import spcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] BLK = 32'h7396_5afb;
   logic clk = 1'b0;
   logic nrst, unlock, pcm, rd, wr, rvalid, cause, cbit, cval, cstart;
   logic [1:0] rate;
   logic [6:0] addr;
   logic [7:0] wdata, rdata;
   int error_cnt = 0;
   int samples_checked = 0;
   int cause_cnt = 0;
   spcs_src i_src (.clk_in(clk), .cs_bit_out(cbit), .cs_valid_out(cval), .cs_start_out(cstart));
   spcs_regs i_dut (.core_clk_in(clk), .nrst_in(nrst), .cs_bit_in(cbit), .cs_valid_in(cval),
      .cs_start_in(cstart), .unlock_in(unlock), .rate_class_in(rate), .pcm_sync_in(pcm),
      .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .lock_change_cause_out(cause));
   always #2.5 clk = ~clk;
   // Cause is a one-cycle pulse, so each one is seen at exactly one falling edge
   always @(negedge clk) begin
      if (cause === 1'b1)
         cause_cnt++;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
      int n;
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      chk("rvalid", {7'h00, rvalid}, 8'h01);
      chk($sformatf("reg_%h", a), rdata & m, e);
   endtask
   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      end_sim();
   end
   initial begin
      {nrst, pcm, rd, wr, rate, addr, wdata} = '0;
      unlock = 1'b1;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      rd_chk(SPCS_ADDR_CHAN1, 8'h00, 8'hff);
      rd_chk(SPCS_ADDR_CHAN2, 8'h00, 8'hff);
      rd_chk(SPCS_ADDR_CHAN3, 8'h00, 8'hff);
      rd_chk(SPCS_ADDR_CHAN4, 8'h01, 8'hff);
      @(negedge clk);
      {wr, addr, wdata} = {1'b1, SPCS_ADDR_CHAN4, 8'hfe};
      @(negedge clk);
      wr = 1'b0;
      rd_chk(SPCS_ADDR_CHAN4, 8'h01, 8'hff);
      rd_chk(7'h20, 8'h00, 8'hff);
      $display("test reset done");
      for (int r = 0; r < 4; r++) begin
         rate = r[1:0];
         unlock = r[0];
         repeat (4) @(negedge clk);
         rd_chk(SPCS_ADDR_SPDSTAT, {1'b0, r[0], r[1:0], 4'h0}, 8'h70);
      end
      chk("cause_cnt", 8'(cause_cnt), 8'h04);
      $display("test status done");
      i_src.send_block(BLK);
      repeat (4) @(negedge clk);
      rd_chk(SPCS_ADDR_CHAN1, 8'h00, 8'hff);
      i_src.send_block(BLK);
      repeat (4) @(negedge clk);
      rd_chk(SPCS_ADDR_CHAN1, 8'hcb, 8'hff);
      rd_chk(SPCS_ADDR_CHAN2, 8'h5a, 8'hff);
      rd_chk(SPCS_ADDR_CHAN3, 8'h96, 8'hff);
      rd_chk(SPCS_ADDR_CHAN4, 8'h03, 8'hff);
      i_src.send_block(~BLK);
      repeat (4) @(negedge clk);
      rd_chk(SPCS_ADDR_CHAN2, 8'h5a, 8'hff);
      $display("test block done");
      end_sim();
   end
endmodule
`default_nettype wire
